// [logic/fiwp_host.sv]
// host sequencer for flash identification and single word program
`timescale 1ns/1ps
`default_nettype none
module fiwp_host
   import fiwp_pkg::*;
#(
   parameter int POLL_LIMIT = PROG_CYC  // program time-out in cycles
)(
   input  wire logic        ref_clk,       // 100 MHz clock
   input  wire logic        srst,          // sync reset, active high
   input  wire logic        cmd_valid,     // command request
   input  wire fiwp_op_t    cmd_op,        // command kind
   input  wire logic [26:0] cmd_addr,      // target address
   input  wire logic [15:0] cmd_data,      // program data
   input  wire logic        byte_mode,     // 8-bit bus mode
   output logic             cmd_ready,     // command accepted when high
   output logic             rsp_valid,     // command finished pulse
   output logic      [15:0] rsp_data,      // read or poll data
   output logic             rsp_err,       // program timed out
   output logic             id_mode,       // identification mode active
   output logic             prog_busy,     // program in progress
   output logic      [26:0] flash_addr,    // address pins
   input  wire logic [15:0] flash_dq_in,   // data pins in
   output logic      [15:0] flash_dq_out,  // data pins out
   output logic             flash_dq_oe_n, // data drive, low drives
   output logic             flash_ce_n,    // chip select
   output logic             flash_oe_n,    // output gate
   output logic             flash_we_n,    // write strobe
   output logic             flash_rst_n,   // hardware reset
   output logic             flash_byte_n   // word mode when high
);

   // ----------------------------------------------------------------
   // sequencer state
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_UNLK1  = 4'h1,
      ST_UNLK2  = 4'h3,
      ST_CMD    = 4'h2,
      ST_PDATA  = 4'h6,
      ST_POLL   = 4'h7,
      ST_SINGLE = 4'h4,
      ST_HWRST  = 4'hC
   } fiwp_st_t;

   fiwp_st_t    state, next_state;
   fiwp_op_t    op, next_op;
   logic        launched, next_launched;
   logic [26:0] addr_q, next_addr;
   logic [15:0] data_q, next_data;
   logic        bm, next_bm;
   logic [15:0] cnt, next_cnt;
   logic        next_ready, next_rsp_valid, next_err, next_id;
   logic        next_pbusy, next_rst_n;
   logic [15:0] next_rsp_data;
   logic        cyc_start, cyc_wr, cyc_done, fin, match;
   logic [26:0] cyc_addr;
   logic [15:0] cyc_data, cyc_rdata, rd_val;

   assign fin    = launched && cyc_done;
   assign rd_val = bm ? {8'h00, cyc_rdata[7:0] & BYTE_MASK} : cyc_rdata;
   assign match  = (cyc_rdata[7] == data_q[7]);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_state     = state;
      next_op        = op;
      next_launched  = launched;
      next_addr      = addr_q;
      next_data      = data_q;
      next_bm        = bm;
      next_cnt       = cnt;
      next_rsp_valid = 1'b0;
      next_rsp_data  = rsp_data;
      next_err       = rsp_err;
      next_id        = id_mode;
      next_pbusy     = prog_busy;
      next_rst_n     = flash_rst_n;
      cyc_wr         = 1'b1;
      cyc_addr       = addr_q;
      cyc_data       = data_q;
      case (state)
         ST_IDLE: if (cmd_valid && cmd_ready) begin
            next_op   = cmd_op;
            next_addr = cmd_addr;
            next_data = byte_mode ? {8'h00, cmd_data[7:0]} : cmd_data;
            next_bm   = byte_mode;
            next_err  = 1'b0;
            case (cmd_op)
               OP_ID_ENTER: next_state = ST_UNLK1;
               OP_PROGRAM: begin
                  next_state = ST_UNLK1;
                  next_pbusy = 1'b1;
               end
               OP_HW_RESET: begin
                  next_state = ST_HWRST;
                  next_rst_n = 1'b0;
                  next_cnt   = RP_CYC;
               end
               default: next_state = ST_SINGLE;
            endcase
         end
         ST_UNLK1: begin
            cyc_addr = unlock_addr(bm, 1'b0);
            cyc_data = D_UNLK1;
            if (fin)
               next_state = ST_UNLK2;
         end
         ST_UNLK2: begin
            cyc_addr = unlock_addr(bm, 1'b1);
            cyc_data = D_UNLK2;
            if (fin)
               next_state = ST_CMD;
         end
         ST_CMD: begin
            cyc_addr = unlock_addr(bm, 1'b0);
            cyc_data = (op == OP_PROGRAM) ? D_PROG : D_IDENT;
            if (fin && op == OP_PROGRAM) begin
               next_state = ST_PDATA;
            end else if (fin) begin
               next_state     = ST_IDLE;
               next_id        = 1'b1;
               next_rsp_valid = 1'b1;
            end
         end
         ST_PDATA: if (fin) begin
            next_state = ST_POLL;
            next_cnt   = 16'(POLL_LIMIT);
         end
         ST_POLL: begin
            // status read at the target until bit 7 shows true data
            cyc_wr = 1'b0;
            if (cnt != 16'h0000)
               next_cnt = cnt - 16'h0001;
            if (fin && match) begin
               next_state     = ST_IDLE;
               next_pbusy     = 1'b0;
               next_rsp_valid = 1'b1;
               next_rsp_data  = rd_val;
            end else if (fin && cnt == 16'h0000) begin
               next_state = ST_HWRST;
               next_err   = 1'b1;
               next_rst_n = 1'b0;
               next_cnt   = RP_CYC;
            end
         end
         ST_SINGLE: begin
            cyc_wr   = (op == OP_ID_EXIT);
            cyc_data = D_RESET;
            if (fin) begin
               next_state     = ST_IDLE;
               next_rsp_valid = 1'b1;
               if (op == OP_ID_EXIT)
                  next_id = 1'b0;
               else
                  next_rsp_data = rd_val;
            end
         end
         ST_HWRST: begin
            // reset pulse, then recovery before the next command
            if (cnt != 16'h0000) begin
               next_cnt = cnt - 16'h0001;
            end else if (!flash_rst_n) begin
               next_rst_n = 1'b1;
               next_cnt   = RH_CYC;
            end else begin
               next_state     = ST_IDLE;
               next_id        = 1'b0;
               next_pbusy     = 1'b0;
               next_rsp_valid = 1'b1;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      cyc_start = !launched && state != ST_IDLE && state != ST_HWRST;
      if (cyc_start)
         next_launched = 1'b1;
      else if (fin)
         next_launched = 1'b0;
      next_ready = (next_state == ST_IDLE);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state        <= ST_IDLE;
         op           <= OP_READ;
         launched     <= 1'b0;
         addr_q       <= 27'h0000000;
         data_q       <= 16'h0000;
         bm           <= 1'b0;
         cnt          <= 16'h0000;
         cmd_ready    <= 1'b0;
         rsp_valid    <= 1'b0;
         rsp_data     <= 16'h0000;
         rsp_err      <= 1'b0;
         id_mode      <= 1'b0;
         prog_busy    <= 1'b0;
         flash_rst_n  <= 1'b1;
         flash_byte_n <= 1'b1;
      end else begin
         state        <= next_state;
         op           <= next_op;
         launched     <= next_launched;
         addr_q       <= next_addr;
         data_q       <= next_data;
         bm           <= next_bm;
         cnt          <= next_cnt;
         cmd_ready    <= next_ready;
         rsp_valid    <= next_rsp_valid;
         rsp_data     <= next_rsp_data;
         rsp_err      <= next_err;
         id_mode      <= next_id;
         prog_busy    <= next_pbusy;
         flash_rst_n  <= next_rst_n;
         flash_byte_n <= !next_bm;
      end
   end

   // ----------------------------------------------------------------
   // bus cycle engine
   // ----------------------------------------------------------------
   fiwp_bus_cyc fiwp_bus_cyc_inst (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .start      (cyc_start),
      .wr         (cyc_wr),
      .addr       (cyc_addr),
      .wdata      (cyc_data),
      .dq_in      (flash_dq_in),
      .done       (cyc_done),
      .rdata      (cyc_rdata),
      .flash_addr (flash_addr),
      .dq_out     (flash_dq_out),
      .dq_oe_n    (flash_dq_oe_n),
      .ce_n       (flash_ce_n),
      .oe_n       (flash_oe_n),
      .we_n       (flash_we_n)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   chk_write_strobes: assert property (
      !flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n)
      else $error("write strobe without proper select or drive");
   chk_data_at_rise: assert property (
      $rose(flash_we_n) |-> !flash_dq_oe_n && $stable(flash_dq_out))
      else $error("data not held at write strobe rise");
   chk_unlock_first: assert property (
      $fell(flash_we_n) && state == ST_UNLK1 |->
         flash_addr == unlock_addr(bm, 1'b0) && flash_dq_out == D_UNLK1)
      else $error("first unlock cycle wrong");
   chk_unlock_second: assert property (
      $fell(flash_we_n) && state == ST_UNLK2 |->
         flash_addr == unlock_addr(bm, 1'b1) && flash_dq_out == D_UNLK2)
      else $error("second unlock cycle wrong");
   chk_entry_code: assert property (
      $fell(flash_we_n) && state == ST_CMD && op == OP_ID_ENTER |->
         flash_dq_out == D_IDENT)
      else $error("identification entry code wrong");
   chk_exit_code: assert property (
      $fell(flash_we_n) && state == ST_SINGLE |-> flash_dq_out == D_RESET)
      else $error("exit code wrong");
   chk_reset_held: assert property (
      $fell(flash_rst_n) |-> !flash_rst_n [*3])
      else $error("hardware reset pulse too short");
   chk_busy_blocks: assert property (
      prog_busy |-> !cmd_ready)
      else $error("command accepted while programming");
   chk_id_leave: assert property (
      $fell(id_mode) |->
         $past(state) == ST_SINGLE || $past(state) == ST_HWRST)
      else $error("identification mode left without exit");
   chk_prog_end: assert property (
      $fell(prog_busy) |-> rsp_valid ##1 cmd_ready)
      else $error("program end not reported");

   cov_id_entry: cover property ($rose(id_mode));
   cov_prog_ok: cover property ($fell(prog_busy) && !rsp_err);
   cov_timeout: cover property ($rose(rsp_err));
   cov_id_read: cover property (id_mode && rsp_valid && op == OP_READ);

endmodule
`default_nettype wire

// [pkg/fiwp_pkg.sv]
// constants, types and helpers for the flash command host
package fiwp_pkg;

   // ----------------------------------------------------------------
   // bus widths and clock
   // ----------------------------------------------------------------
   localparam int ADDR_W = 27;
   localparam int DATA_W = 16;
   localparam int CLK_NS = 10;

   // ----------------------------------------------------------------
   // command addresses and codes
   // ----------------------------------------------------------------
   localparam logic [26:0] UNLK_A1_W = 27'h0000555;
   localparam logic [26:0] UNLK_A2_W = 27'h00002AA;
   localparam logic [26:0] UNLK_A1_B = 27'h0000AAA;
   localparam logic [26:0] UNLK_A2_B = 27'h0000555;
   localparam logic [15:0] D_UNLK1   = 16'h00AA;
   localparam logic [15:0] D_UNLK2   = 16'h0055;
   localparam logic [15:0] D_IDENT   = 16'h0090;
   localparam logic [15:0] D_PROG    = 16'h00A0;
   localparam logic [15:0] D_RESET   = 16'h00F0;
   localparam logic [7:0]  BYTE_MASK = 8'hFF;

   // identification offsets, added to base or sector address
   localparam logic [26:0] OFS_MFR    = 27'h0000000;
   localparam logic [26:0] OFS_DEV1   = 27'h0000001;
   localparam logic [26:0] OFS_LOCK   = 27'h0000002;
   localparam logic [26:0] OFS_SECURE = 27'h0000003;
   localparam logic [26:0] OFS_DEV2   = 27'h000000E;
   localparam logic [26:0] OFS_DEV3   = 27'h000000F;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int T_WP_NS   = 50;
   localparam int T_WPH_NS  = 30;
   localparam int T_ACC_NS  = 100;
   localparam int T_RP_NS   = 500;
   localparam int T_RH_NS   = 200;
   localparam int T_PROG_US = 200;
   localparam logic [7:0]  WP_CYC  = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0]  WPH_CYC = 8'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0]  ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] RP_CYC  = 16'((T_RP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] RH_CYC  = 16'((T_RH_NS + CLK_NS - 1) / CLK_NS);
   localparam int          PROG_CYC = (T_PROG_US * 1000) / CLK_NS;

   // ----------------------------------------------------------------
   // user commands
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_ID_ENTER = 3'h0,
      OP_ID_EXIT  = 3'h1,
      OP_READ     = 3'h2,
      OP_PROGRAM  = 3'h3,
      OP_HW_RESET = 3'h4
   } fiwp_op_t;

   // unlock address for word or byte mode, first or second cycle
   function automatic logic [26:0] unlock_addr(input logic byte_md,
                                               input logic second);
      if (byte_md)
         return second ? UNLK_A2_B : UNLK_A1_B;
      else
         return second ? UNLK_A2_W : UNLK_A1_W;
   endfunction

endpackage

// [logic/fiwp_bus_cyc.sv]
// single read or write cycle engine on the flash strobes
`timescale 1ns/1ps
`default_nettype none
module fiwp_bus_cyc
   import fiwp_pkg::*;
(
   input  wire logic              ref_clk,   // clock
   input  wire logic              srst,      // sync reset
   input  wire logic              start,     // begin a cycle
   input  wire logic              wr,        // write when high
   input  wire logic [26:0]       addr,      // cycle address
   input  wire logic [15:0]       wdata,     // write data
   input  wire logic [15:0]       dq_in,     // data pins in
   output logic                   done,      // cycle finished pulse
   output logic      [15:0]       rdata,     // captured read data
   output logic      [26:0]       flash_addr,// address pins
   output logic      [15:0]       dq_out,    // data pins out
   output logic                   dq_oe_n,   // data drive, low drives
   output logic                   ce_n,      // chip select
   output logic                   oe_n,      // output gate
   output logic                   we_n       // write strobe
);

   typedef enum logic [1:0] {
      CY_IDLE  = 2'h0,
      CY_SETUP = 2'h1,
      CY_STRB  = 2'h3,
      CY_HOLD  = 2'h2
   } fiwp_cy_t;

   fiwp_cy_t    cy, next_cy;
   logic [7:0]  cnt, next_cnt;
   logic        wr_q, next_wr;
   logic [26:0] next_addr;
   logic [15:0] next_dq, next_rdata;
   logic        next_dq_oe_n, next_ce_n, next_oe_n, next_we_n, next_done;

   always_comb begin
      next_cy      = cy;
      next_cnt     = cnt;
      next_wr      = wr_q;
      next_addr    = flash_addr;
      next_dq      = dq_out;
      next_dq_oe_n = dq_oe_n;
      next_ce_n    = ce_n;
      next_oe_n    = oe_n;
      next_we_n    = we_n;
      next_done    = 1'b0;
      next_rdata   = rdata;
      case (cy)
         CY_IDLE: if (start) begin
            next_cy      = CY_SETUP;
            next_wr      = wr;
            next_addr    = addr;
            next_dq      = wdata;
            next_ce_n    = 1'b0;
            next_dq_oe_n = !wr;
            next_oe_n    = wr;
         end
         CY_SETUP: begin
            // address latched on this falling strobe
            next_cy   = CY_STRB;
            next_cnt  = wr_q ? WP_CYC : ACC_CYC;
            next_we_n = !wr_q;
         end
         CY_STRB: if (cnt <= 8'h01) begin
            // data latched on this rising strobe, held through hold
            next_cy   = CY_HOLD;
            next_we_n = 1'b1;
            next_oe_n = 1'b1;
            next_cnt  = WPH_CYC;
            if (!wr_q)
               next_rdata = dq_in;
         end else begin
            next_cnt = cnt - 8'h01;
         end
         CY_HOLD: if (cnt <= 8'h01) begin
            next_cy      = CY_IDLE;
            next_ce_n    = 1'b1;
            next_dq_oe_n = 1'b1;
            next_done    = 1'b1;
         end else begin
            next_cnt = cnt - 8'h01;
         end
         default: next_cy = CY_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cy         <= CY_IDLE;
         cnt        <= 8'h00;
         wr_q       <= 1'b0;
         flash_addr <= 27'h0000000;
         dq_out     <= 16'h0000;
         dq_oe_n    <= 1'b1;
         ce_n       <= 1'b1;
         oe_n       <= 1'b1;
         we_n       <= 1'b1;
         done       <= 1'b0;
         rdata      <= 16'h0000;
      end else begin
         cy         <= next_cy;
         cnt        <= next_cnt;
         wr_q       <= next_wr;
         flash_addr <= next_addr;
         dq_out     <= next_dq;
         dq_oe_n    <= next_dq_oe_n;
         ce_n       <= next_ce_n;
         oe_n       <= next_oe_n;
         we_n       <= next_we_n;
         done       <= next_done;
         rdata      <= next_rdata;
      end
   end

endmodule
`default_nettype wire

// [tb/fiwp_flash_model.sv]
// behavioural flash device on the far side of the host
`timescale 1ns/1ps
`default_nettype none
module fiwp_flash_model
   import fiwp_pkg::*;
#(
   parameter logic [15:0] MFR_CODE  = 16'h00C5, // arbitrary value
   parameter logic [15:0] DEV_CODE1 = 16'h1357, // arbitrary value
   parameter logic [15:0] DEV_CODE2 = 16'h2468, // arbitrary value
   parameter logic [15:0] DEV_CODE3 = 16'h3579, // arbitrary value
   parameter logic [15:0] SEC_IND   = 16'h0099, // factory locked
   parameter logic [10:0] LOCK_SECT = 11'h003,  // locked sector
   parameter int          PROG_NS   = 500,      // fast program time
   parameter int          SLOW_NS   = 5000      // slow program time
)(
   input  wire logic        flash_ce_n,   // chip select
   input  wire logic        flash_oe_n,   // output gate
   input  wire logic        flash_we_n,   // write strobe
   input  wire logic        flash_rst_n,  // hardware reset
   input  wire logic        flash_byte_n, // word mode when high
   input  wire logic        slow,         // long program time
   input  wire logic [26:0] flash_addr,   // address pins
   input  wire logic [15:0] flash_dq_out, // data from host
   output logic      [15:0] dev_q         // data toward host
);
   logic [15:0] mem [256];
   logic [15:0] pd = 16'h0000;
   logic [15:0] lastv = 16'h0000;
   logic [15:0] val;
   logic [26:0] la = 27'h0000000;
   logic [7:0]  pa = 8'h00;
   logic [1:0]  step = 2'h0;
   logic        busy = 1'b0;
   logic        idm = 1'b0;
   logic        drv;
   int          gen = 0;

   initial foreach (mem[i]) mem[i] = 16'hFFFF;

   // ----------------------------------------------------------------
   // reads
   // ----------------------------------------------------------------
   assign drv = !flash_ce_n && !flash_oe_n && flash_we_n && flash_rst_n;
   always_comb begin
      if (busy)
         val = ~pd;
      else if (idm) begin
         case (flash_addr[7:0])
            8'h00: val = MFR_CODE;
            8'h01: val = DEV_CODE1;
            8'h0E: val = DEV_CODE2;
            8'h0F: val = DEV_CODE3;
            8'h03: val = SEC_IND;
            8'h02: val = {15'h0000, flash_addr[26:16] == LOCK_SECT};
            default: val = 16'h0000;
         endcase
      end else
         val = mem[flash_addr[7:0]];
      if (!flash_byte_n)
         val = {8'h00, val[7:0]};
   end
   // released bus shows the inverse of the last value
   always @(val or drv) if (drv) lastv = val;
   assign dev_q = drv ? val : ~lastv;

   // ----------------------------------------------------------------
   // writes
   // ----------------------------------------------------------------
   task automatic wr_cmd(input logic [26:0] a, input logic [15:0] d);
      logic [15:0] c;
      logic [26:0] u1;
      logic [26:0] u2;
      int          g;
      c  = flash_byte_n ? d : {8'h00, d[7:0]};
      u1 = flash_byte_n ? UNLK_A1_W : UNLK_A1_B;
      u2 = flash_byte_n ? UNLK_A2_W : UNLK_A2_B;
      if (!flash_rst_n || busy)
         return;
      case (step)
         2'h0: begin
            if (c == D_RESET)
               idm = 1'b0;
            else if (a == u1 && c == D_UNLK1)
               step = 2'h1;
         end
         2'h1: step = (a == u2 && c == D_UNLK2) ? 2'h2 : 2'h0;
         2'h2: begin
            step = (a == u1 && c == D_PROG) ? 2'h3 : 2'h0;
            if (a == u1 && c == D_IDENT)
               idm = 1'b1;
         end
         default: begin
            step = 2'h0;
            pa = a[7:0];
            pd = flash_byte_n ? d : {8'hFF, d[7:0]};
            busy = 1'b1;
            gen++;
            g = gen;
            fork
               begin
                  #(slow ? SLOW_NS : PROG_NS);
                  if (g == gen) begin
                     mem[pa] = mem[pa] & pd;
                     busy = 1'b0;
                  end
               end
            join_none
         end
      endcase
   endtask

   // address on last falling strobe, data on first rising
   always @(negedge flash_we_n or negedge flash_ce_n)
      if (!flash_we_n && !flash_ce_n && flash_oe_n)
         la = flash_addr;
   always @(posedge flash_we_n or posedge flash_ce_n)
      if ((flash_we_n ^ flash_ce_n) && flash_oe_n)
         wr_cmd(la, flash_dq_out);
   always @(negedge flash_rst_n) begin
      gen++;
      busy = 1'b0;
      step = 2'h0;
      idm = 1'b0;
   end
endmodule
`default_nettype wire

// [tb/tb_flash_id_and_word_program_cmds.sv]
// self-checking bench for the flash command host
`timescale 1ns/1ps
`default_nettype none
module tb_flash_id_and_word_program_cmds
   import fiwp_pkg::*;
;
   localparam logic [15:0] MFR = 16'h00C5; // arbitrary value
   localparam logic [15:0] DV1 = 16'h1357; // arbitrary value
   localparam logic [15:0] DV2 = 16'h2468; // arbitrary value
   localparam logic [15:0] DV3 = 16'h3579; // arbitrary value
   fiwp_op_t    cmd_op;
   logic [26:0] cmd_addr, flash_addr;
   logic [15:0] cmd_data, rsp_data, flash_dq_in, flash_dq_out, dev_q;
   logic        ref_clk, srst, cmd_valid, byte_mode, slow, cmd_ready;
   logic        rsp_valid, rsp_err, id_mode, prog_busy, flash_dq_oe_n;
   logic        flash_ce_n, flash_oe_n, flash_we_n, flash_rst_n;
   logic        flash_byte_n;
   logic [26:0] wa[$];
   logic [15:0] wd[$];
   int          err_total = 0, tests_run = 0, cyc = 0, rst_low = 0;

   assign flash_dq_in = flash_dq_oe_n ? dev_q : flash_dq_out;
   fiwp_host #(.POLL_LIMIT(200)) fiwp_host_inst (.ref_clk, .srst,
      .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .byte_mode, .cmd_ready,
      .rsp_valid, .rsp_data, .rsp_err, .id_mode, .prog_busy, .flash_addr,
      .flash_dq_in, .flash_dq_out, .flash_dq_oe_n, .flash_ce_n,
      .flash_oe_n, .flash_we_n, .flash_rst_n, .flash_byte_n);
   fiwp_flash_model #(.MFR_CODE(MFR), .DEV_CODE1(DV1), .DEV_CODE2(DV2),
      .DEV_CODE3(DV3), .SEC_IND(16'h0099), .LOCK_SECT(11'h003))
      fiwp_flash_model_inst (.flash_ce_n, .flash_oe_n, .flash_we_n,
      .flash_rst_n, .flash_byte_n, .slow, .flash_addr, .flash_dq_out,
      .dev_q);

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(negedge ref_clk) begin
      cyc++;
      if (!flash_rst_n) rst_low++;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end
   always @(posedge flash_we_n)
      if (!flash_ce_n) begin
         wa.push_back(flash_addr);
         wd.push_back(flash_dq_out);
         chk(flash_oe_n, 1'b1);
      end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic do_cmd(input fiwp_op_t op, input logic [26:0] a,
                         input logic [15:0] d, input logic bm);
      @(posedge ref_clk) #1;
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      byte_mode = bm;
      cmd_valid = 1'b1;
      // flags sampled between edges, never on the edge that moves them
      while (cmd_ready !== 1'b1) @(posedge ref_clk) #1;
      @(posedge ref_clk) #1;
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1) @(posedge ref_clk) #1;
   endtask
   task automatic rd(input logic [26:0] a, input logic [15:0] e,
                     input logic bm);
      do_cmd(OP_READ, a, 16'h0000, bm);
      chk(rsp_data, e);
   endtask
   task automatic chk_wr(input int i, input logic [26:0] a,
                         input logic [15:0] d);
      chk(wa[i], a);
      chk(wd[i], d);
   endtask
   task automatic close_out();
      $display("checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_id_word();
      wa.delete();
      wd.delete();
      do_cmd(OP_ID_ENTER, 27'h0, 16'h0, 1'b0);
      chk(wa.size(), 3);
      chk_wr(0, 27'h555, 16'h00AA);
      chk_wr(1, 27'h2AA, 16'h0055);
      chk_wr(2, 27'h555, 16'h0090);
      chk(id_mode, 1'b1);
      rd(OFS_MFR, MFR, 1'b0);
      rd(OFS_MFR, MFR, 1'b0);
      rd(OFS_DEV1, DV1, 1'b0);
      rd(OFS_DEV2, DV2, 1'b0);
      rd(OFS_DEV3, DV3, 1'b0);
      rd(OFS_SECURE, 16'h0099, 1'b0);
      rd(27'h0030002, 16'h0001, 1'b0);
      rd(27'h0040002, 16'h0000, 1'b0);
      do_cmd(OP_ID_EXIT, 27'h0001234, 16'h0, 1'b0);
      chk_wr(3, 27'h0001234, 16'h00F0);
      chk(id_mode, 1'b0);
      rd(27'h0000005, 16'hFFFF, 1'b0);
   endtask
   task automatic t_id_byte();
      wa.delete();
      wd.delete();
      do_cmd(OP_ID_ENTER, 27'h0, 16'h0, 1'b1);
      chk(flash_byte_n, 1'b0);
      chk(wa[0], 27'hAAA);
      chk(wa[1], 27'h555);
      chk(wa[2], 27'hAAA);
      rd(OFS_DEV1, {8'h00, DV1[7:0]}, 1'b1);
      do_cmd(OP_ID_EXIT, 27'h0, 16'h0, 1'b1);
      chk(id_mode, 1'b0);
   endtask
   task automatic t_prog();
      wa.delete();
      wd.delete();
      do_cmd(OP_PROGRAM, 27'h0000010, 16'hF0F0, 1'b0);
      chk(wa.size(), 4);
      chk_wr(0, 27'h555, 16'h00AA);
      chk_wr(1, 27'h2AA, 16'h0055);
      chk_wr(2, 27'h555, 16'h00A0);
      chk_wr(3, 27'h0000010, 16'hF0F0);
      chk(rsp_err, 1'b0);
      chk(prog_busy, 1'b0);
      rd(27'h0000010, 16'hF0F0, 1'b0);
      do_cmd(OP_PROGRAM, 27'h0000010, 16'h3CFF, 1'b0);
      rd(27'h0000010, 16'h30F0, 1'b0);
      do_cmd(OP_PROGRAM, 27'h0010005, 16'h1234, 1'b0);
      rd(27'h0010005, 16'h1234, 1'b0);
   endtask
   task automatic t_prog_byte();
      wa.delete();
      wd.delete();
      do_cmd(OP_PROGRAM, 27'h0000021, 16'h1234, 1'b1);
      chk(wa[0], 27'hAAA);
      chk(wa[2], 27'hAAA);
      chk(wa[3], 27'h0000021);
      chk(wd[3][7:0], 8'h34);
      rd(27'h0000021, 16'h0034, 1'b1);
   endtask
   task automatic t_abort();
      slow = 1'b1;
      rst_low = 0;
      do_cmd(OP_PROGRAM, 27'h0000040, 16'h5A5A, 1'b0);
      chk(rsp_err, 1'b1);
      chk(rst_low >= RP_CYC, 1'b1);
      slow = 1'b0;
      rd(27'h0000040, 16'hFFFF, 1'b0);
      do_cmd(OP_PROGRAM, 27'h0000040, 16'h5A5A, 1'b0);
      chk(rsp_err, 1'b0);
      rd(27'h0000040, 16'h5A5A, 1'b0);
      do_cmd(OP_ID_ENTER, 27'h0, 16'h0, 1'b0);
      do_cmd(OP_HW_RESET, 27'h0, 16'h0, 1'b0);
      chk(id_mode, 1'b0);
      rd(27'h0000040, 16'h5A5A, 1'b0);
   endtask

   initial begin
      srst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = OP_READ;
      cmd_addr = 27'h0000000;
      cmd_data = 16'h0000;
      byte_mode = 1'b0;
      slow = 1'b0;
      repeat (16) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      repeat (2) @(posedge ref_clk);
      t_id_word();
      t_id_byte();
      t_prog();
      t_prog_byte();
      t_abort();
      close_out();
   end
endmodule
`default_nettype wire
